// ===== pkg/lps_pkg.sv
// Overview of operation
// R1 - Selector bits 7:3, reset 1, picks sources 0-7
// R2 - Codes 8-18 give DAC flags, dividers; 6 reserved
// R3 - Type bits 2:0, reset 6: push-pull, inverted, open-drain
// R4 - Software avoids codes 17/18 while pin two shows loop-two lock
// R5 - Selector and type share register lock_pin_one_config
// R6 - Second ref divider bits 4:0 of 0x161, reset 2
// R7 - Divider divides by 1-30; zero is never programmed
// R8 - Pin follows new fields at once, no commit
package lps_pkg;

    // Register port widths
    localparam int unsigned ADDR_W = 9;
    localparam int unsigned DATA_W = 8;
    typedef logic [ADDR_W-1:0] lps_addr_t;
    typedef logic [DATA_W-1:0] lps_data_t;

    // Register offsets
    localparam lps_addr_t OFF_PIN_CFG = 9'h15F;
    localparam lps_addr_t OFF_REF_DIV = 9'h161;
    localparam lps_addr_t OFF_IRQ_STAT = 9'h1F0;
    localparam lps_addr_t OFF_IRQ_MASK = 9'h1F1;
    localparam lps_addr_t OFF_PIN_STATE = 9'h1F2;

    // Field positions and widths
    localparam int unsigned SEL_LSB = 3;
    localparam int unsigned SEL_W = 5;
    localparam int unsigned TYPE_LSB = 0;
    localparam int unsigned TYPE_W = 3;
    localparam int unsigned DIV_LSB = 0;
    localparam int unsigned DIV_W = 5;

    // Reset values
    localparam logic [SEL_W-1:0] SEL_RST = 5'h01;
    localparam logic [TYPE_W-1:0] TYPE_RST = 3'h6;
    localparam logic [DIV_W-1:0] DIV_RST = 5'h02;

    // Source selector codes
    localparam logic [SEL_W-1:0] SRC_LOW = 5'h00;
    localparam logic [SEL_W-1:0] SRC_LOCK_ONE = 5'h01;
    localparam logic [SEL_W-1:0] SRC_LOCK_TWO = 5'h02;
    localparam logic [SEL_W-1:0] SRC_LOCK_BOTH = 5'h03;
    localparam logic [SEL_W-1:0] SRC_HOLDOVER = 5'h04;
    localparam logic [SEL_W-1:0] SRC_DAC_LOCKED = 5'h05;
    localparam logic [SEL_W-1:0] SRC_RESERVED = 5'h06;
    localparam logic [SEL_W-1:0] SRC_READBACK = 5'h07;
    localparam logic [SEL_W-1:0] SRC_DAC_RAIL = 5'h08;
    localparam logic [SEL_W-1:0] SRC_DAC_LOW = 5'h09;
    localparam logic [SEL_W-1:0] SRC_DAC_HIGH = 5'h0A;
    localparam logic [SEL_W-1:0] SRC_FB_ONE = 5'h0B;
    localparam logic [SEL_W-1:0] SRC_FB_ONE_HALF = 5'h0C;
    localparam logic [SEL_W-1:0] SRC_FB_TWO = 5'h0D;
    localparam logic [SEL_W-1:0] SRC_FB_TWO_HALF = 5'h0E;
    localparam logic [SEL_W-1:0] SRC_REF_ONE = 5'h0F;
    localparam logic [SEL_W-1:0] SRC_REF_ONE_HALF = 5'h10;
    localparam logic [SEL_W-1:0] SRC_REF_TWO = 5'h11;
    localparam logic [SEL_W-1:0] SRC_REF_TWO_HALF = 5'h12;

    // Drive type codes
    localparam logic [TYPE_W-1:0] TYPE_PP = 3'h3;
    localparam logic [TYPE_W-1:0] TYPE_PP_INV = 3'h4;
    localparam logic [TYPE_W-1:0] TYPE_OD = 3'h6;

    // Pin-two selector codes that clash with the second ref divider
    localparam logic [SEL_W-1:0] PIN2_LOCK_TWO = 5'h02;
    localparam logic [SEL_W-1:0] PIN2_LOCK_BOTH = 5'h03;

    // Interrupt status bits
    localparam int unsigned IRQ_W = 5;
    localparam int unsigned IRQ_RISE = 0;
    localparam int unsigned IRQ_FALL = 1;
    localparam int unsigned IRQ_DIV_ZERO = 2;
    localparam int unsigned IRQ_CONFLICT = 3;
    localparam int unsigned IRQ_RSVD_CODE = 4;

    // Pin state register bits
    localparam int unsigned ST_LEVEL = 0;
    localparam int unsigned ST_OUT = 1;
    localparam int unsigned ST_OE = 2;
    localparam int unsigned ST_DIV_OK = 3;

endpackage

// ===== pkg/lps_div_if.sv
// Link between the pin logic and the second-loop reference divider
interface lps_div_if;
    logic [lps_pkg::DIV_W-1:0] divide_value;
    logic ref_tick;
    logic div_pulse;
    logic div_half;
    logic div_valid;

    modport ctl (
        output divide_value,
        output ref_tick,
        input div_pulse,
        input div_half,
        input div_valid
    );

    modport div (
        input divide_value,
        input ref_tick,
        output div_pulse,
        output div_half,
        output div_valid
    );
endinterface

// ===== logic/lps_ref_div.sv
module lps_ref_div (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Divider link
    lps_div_if.div dv
);
    import lps_pkg::*;

    logic [DIV_W-1:0] cnt_r;
    logic pulse_r;
    logic half_r;
    logic valid_r;

    // Count reference ticks up to the programmed value; zero keeps the count cleared
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
            pulse_r <= 1'b0;
        end else begin
            pulse_r <= 1'b0;
            if (dv.divide_value == '0) begin
                cnt_r <= '0; // [R7]
            end else if (dv.ref_tick) begin
                if (cnt_r >= dv.divide_value - 5'h01) begin
                    cnt_r <= '0; // [R7]
                    pulse_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 5'h01;
                end
            end
        end
    end

    // Halved output toggles on each divided pulse
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            half_r <= 1'b0;
        end else if (pulse_r) begin
            half_r <= ~half_r;
        end
    end

    // Flags a usable divide value
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            valid_r <= 1'b0;
        end else begin
            valid_r <= (dv.divide_value != '0);
        end
    end

    assign dv.div_pulse = pulse_r;
    assign dv.div_half = half_r;
    assign dv.div_valid = valid_r;

    property p_zero_silent;
        @(posedge clk) disable iff (!arst_n)
        (dv.divide_value == '0) |=> !pulse_r;
    endproperty
    a_zero_silent: assert property (p_zero_silent) else $error("divider pulsed at zero"); // [R7]

    property p_div_three;
        @(posedge clk) disable iff (!arst_n)
        (dv.divide_value == 5'h03 && dv.ref_tick && pulse_r) ##1
        (dv.divide_value == 5'h03 && !dv.ref_tick) [*1] |=> !pulse_r;
    endproperty
    a_div_three: assert property (p_div_three) else $error("pulse without tick"); // [R7]

endmodule

// ===== logic/lps_lock_pin.sv
module lps_lock_pin (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire lps_pkg::lps_addr_t reg_addr,
    input wire lps_pkg::lps_data_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [lps_pkg::DATA_W-1:0] reg_rdata,
    // Internal status sources
    input wire logic loop_one_locked,
    input wire logic loop_two_locked,
    input wire logic holdover_active,
    input wire logic dac_locked,
    input wire logic dac_rail,
    input wire logic dac_low,
    input wire logic dac_high,
    input wire logic readback_bit,
    // Divider sources
    input wire logic loop_one_fb_div,
    input wire logic loop_two_fb_div,
    input wire logic loop_one_ref_div,
    input wire logic loop_two_ref_tick,
    // Second status pin configuration
    input wire logic [lps_pkg::SEL_W-1:0] pin_two_source_select,
    // Status pin one
    output logic status_pin_one_out,
    output logic status_pin_one_oe,
    // Divider and interrupt outputs
    output logic ref_div_two_pulse,
    output logic irq
);
    import lps_pkg::*;

    logic [SEL_W-1:0] sel_r;
    logic [TYPE_W-1:0] type_r;
    logic [DIV_W-1:0] div_r;
    logic [IRQ_W-1:0] stat_r;
    logic [IRQ_W-1:0] stat_nxt;
    logic [IRQ_W-1:0] mask_r;
    logic [IRQ_W-1:0] ev_set;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic [2:0] src_prev_r;
    logic [2:0] src_half_r;
    logic sel_lvl;
    logic lvl_prev_r;
    logic pin_out_r;
    logic pin_oe_r;
    logic irq_r;
    logic wr_cfg;
    logic wr_div;
    logic conflict;

    lps_div_if dv_if ();

    // Reserved selector or drive type codes
    function automatic logic lps_rsvd_code(input logic [SEL_W-1:0] s, input logic [TYPE_W-1:0] t);
        logic bad_sel;
        logic bad_type;
        bad_sel = (s == SRC_RESERVED) || (s > SRC_REF_TWO_HALF);
        bad_type = (t != TYPE_PP) && (t != TYPE_PP_INV) && (t != TYPE_OD);
        return bad_sel || bad_type;
    endfunction

    // Rising edge of a level against its previous sample
    function automatic logic lps_rise(input logic now, input logic prev);
        return now & ~prev;
    endfunction

    assign wr_cfg = reg_wr && (reg_addr == OFF_PIN_CFG);
    assign wr_div = reg_wr && (reg_addr == OFF_REF_DIV);

    // Pin configuration fields; new values take effect at once
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_r <= SEL_RST; // [R1]
            type_r <= TYPE_RST; // [R3]
        end else if (wr_cfg) begin
            sel_r <= reg_wdata[SEL_LSB +: SEL_W]; // [R5] [R8]
            type_r <= reg_wdata[TYPE_LSB +: TYPE_W]; // [R5] [R8]
        end
    end

    // Second-loop reference divide value, upper bits not stored
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_r <= DIV_RST; // [R6]
        end else if (wr_div) begin
            div_r <= reg_wdata[DIV_LSB +: DIV_W]; // [R6]
        end
    end

    // Interrupt mask
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_r <= '0;
        end else if (reg_wr && reg_addr == OFF_IRQ_MASK) begin
            mask_r <= reg_wdata[IRQ_W-1:0];
        end
    end

    // Second-loop reference divider
    assign dv_if.divide_value = div_r; // [R7]
    assign dv_if.ref_tick = loop_two_ref_tick;

    lps_ref_div u_ref_div (
        .clk(clk),
        .arst_n(arst_n),
        .dv(dv_if.div)
    );

    // Halved copies of the external divider outputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            src_prev_r <= '0;
            src_half_r <= '0;
        end else begin
            src_prev_r <= {loop_one_ref_div, loop_two_fb_div, loop_one_fb_div};
            src_half_r[0] <= src_half_r[0] ^ lps_rise(loop_one_fb_div, src_prev_r[0]); // [R2]
            src_half_r[1] <= src_half_r[1] ^ lps_rise(loop_two_fb_div, src_prev_r[1]); // [R2]
            src_half_r[2] <= src_half_r[2] ^ lps_rise(loop_one_ref_div, src_prev_r[2]); // [R2]
        end
    end

    // Source selector; reserved and unused codes drive low
    always_comb begin
        unique case (sel_r)
            SRC_LOW: sel_lvl = 1'b0; // [R1]
            SRC_LOCK_ONE: sel_lvl = loop_one_locked; // [R1]
            SRC_LOCK_TWO: sel_lvl = loop_two_locked; // [R1]
            SRC_LOCK_BOTH: sel_lvl = loop_one_locked & loop_two_locked; // [R1]
            SRC_HOLDOVER: sel_lvl = holdover_active; // [R1]
            SRC_DAC_LOCKED: sel_lvl = dac_locked; // [R1]
            SRC_READBACK: sel_lvl = readback_bit; // [R1]
            SRC_DAC_RAIL: sel_lvl = dac_rail; // [R2]
            SRC_DAC_LOW: sel_lvl = dac_low; // [R2]
            SRC_DAC_HIGH: sel_lvl = dac_high; // [R2]
            SRC_FB_ONE: sel_lvl = loop_one_fb_div; // [R2]
            SRC_FB_ONE_HALF: sel_lvl = src_half_r[0]; // [R2]
            SRC_FB_TWO: sel_lvl = loop_two_fb_div; // [R2]
            SRC_FB_TWO_HALF: sel_lvl = src_half_r[1]; // [R2]
            SRC_REF_ONE: sel_lvl = loop_one_ref_div; // [R2]
            SRC_REF_ONE_HALF: sel_lvl = src_half_r[2]; // [R2]
            SRC_REF_TWO: sel_lvl = dv_if.div_pulse; // [R2]
            SRC_REF_TWO_HALF: sel_lvl = dv_if.div_half; // [R2]
            default: sel_lvl = 1'b0; // [R2]
        endcase
    end

    // Pin drive per type; reserved types release the pin
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_out_r <= 1'b0;
            pin_oe_r <= 1'b0;
        end else begin
            unique case (type_r)
                TYPE_PP: begin
                    pin_out_r <= sel_lvl; // [R3]
                    pin_oe_r <= 1'b1;
                end
                TYPE_PP_INV: begin
                    pin_out_r <= ~sel_lvl; // [R3]
                    pin_oe_r <= 1'b1;
                end
                TYPE_OD: begin
                    pin_out_r <= 1'b0; // [R3]
                    pin_oe_r <= ~sel_lvl; // [R3]
                end
                default: begin
                    pin_out_r <= 1'b0;
                    pin_oe_r <= 1'b0;
                end
            endcase
        end
    end

    // Previous selected level for edge events
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lvl_prev_r <= 1'b0;
        end else begin
            lvl_prev_r <= sel_lvl;
        end
    end

    // Clash with the second pin showing loop-two lock
    assign conflict = ((sel_r == SRC_REF_TWO) || (sel_r == SRC_REF_TWO_HALF)) &&
                      ((pin_two_source_select == PIN2_LOCK_TWO) ||
                       (pin_two_source_select == PIN2_LOCK_BOTH)); // [R4]

    // Event sources
    always_comb begin
        ev_set = '0;
        ev_set[IRQ_RISE] = lps_rise(sel_lvl, lvl_prev_r);
        ev_set[IRQ_FALL] = lps_rise(lvl_prev_r, sel_lvl);
        ev_set[IRQ_DIV_ZERO] = wr_div && (reg_wdata[DIV_LSB +: DIV_W] == '0); // [R7]
        ev_set[IRQ_CONFLICT] = conflict; // [R4]
        ev_set[IRQ_RSVD_CODE] = wr_cfg && lps_rsvd_code(reg_wdata[SEL_LSB +: SEL_W],
                                                        reg_wdata[TYPE_LSB +: TYPE_W]);
    end

    // Sticky status, write one to clear; a new event wins over the clear
    always_comb begin
        stat_nxt = stat_r;
        if (reg_wr && reg_addr == OFF_IRQ_STAT) begin
            stat_nxt = stat_r & ~reg_wdata[IRQ_W-1:0];
        end
        stat_nxt = stat_nxt | ev_set;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stat_r <= '0;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    // Level interrupt from unmasked status
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(stat_r & mask_r);
        end
    end

    // Read data mux; unmapped addresses read zero
    always_comb begin
        rdata_nxt = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                OFF_PIN_CFG: begin
                    rdata_nxt[SEL_LSB +: SEL_W] = sel_r;
                    rdata_nxt[TYPE_LSB +: TYPE_W] = type_r;
                end
                OFF_REF_DIV: rdata_nxt[DIV_LSB +: DIV_W] = div_r; // [R6]
                OFF_IRQ_STAT: rdata_nxt[IRQ_W-1:0] = stat_r;
                OFF_IRQ_MASK: rdata_nxt[IRQ_W-1:0] = mask_r;
                OFF_PIN_STATE: begin
                    rdata_nxt[ST_LEVEL] = sel_lvl;
                    rdata_nxt[ST_OUT] = pin_out_r;
                    rdata_nxt[ST_OE] = pin_oe_r;
                    rdata_nxt[ST_DIV_OK] = dv_if.div_valid;
                end
                default: rdata_nxt = '0;
            endcase
        end
    end

    // Read data stand for one cycle only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Outputs
    assign reg_rdata = rdata_r;
    assign status_pin_one_out = pin_out_r;
    assign status_pin_one_oe = pin_oe_r;
    assign ref_div_two_pulse = dv_if.div_pulse;
    assign irq = irq_r;

    property p_cfg_write;
        @(posedge clk) disable iff (!arst_n)
        wr_cfg |=> (sel_r == $past(reg_wdata[7:3])) && (type_r == $past(reg_wdata[2:0]));
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write not stored"); // [R5]

    property p_both_locks;
        @(posedge clk) disable iff (!arst_n)
        (sel_r == 5'h03 && type_r == 3'h3 && !wr_cfg) |=>
        pin_oe_r && (pin_out_r == ($past(loop_one_locked) & $past(loop_two_locked)));
    endproperty
    a_both_locks: assert property (p_both_locks) else $error("combined lock not on pin"); // [R1]

    property p_low_code;
        @(posedge clk) disable iff (!arst_n)
        (sel_r == 5'h00 && type_r == 3'h3 && !wr_cfg) |=> !pin_out_r && pin_oe_r;
    endproperty
    a_low_code: assert property (p_low_code) else $error("code zero not low"); // [R1]

    property p_reserved_src;
        @(posedge clk) disable iff (!arst_n)
        (sel_r == 5'h06 || sel_r > 5'h12) |-> !sel_lvl;
    endproperty
    a_reserved_src: assert property (p_reserved_src) else $error("reserved source not low"); // [R2]

    property p_dac_high;
        @(posedge clk) disable iff (!arst_n)
        (sel_r == 5'h0A && type_r == 3'h3 && !wr_cfg) |=> pin_out_r == $past(dac_high);
    endproperty
    a_dac_high: assert property (p_dac_high) else $error("dac high not on pin"); // [R2]

    property p_open_drain;
        @(posedge clk) disable iff (!arst_n)
        (arst_n && type_r == 3'h6 && !wr_cfg) |=> !pin_out_r && (pin_oe_r == !$past(sel_lvl));
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain wrong"); // [R3]

    property p_inverted;
        @(posedge clk) disable iff (!arst_n)
        (type_r == 3'h4 && !wr_cfg) |=> pin_oe_r && (pin_out_r != $past(sel_lvl));
    endproperty
    a_inverted: assert property (p_inverted) else $error("inverted drive wrong"); // [R3]

    property p_conflict_flag;
        @(posedge clk) disable iff (!arst_n)
        ((sel_r == 5'h11 || sel_r == 5'h12) &&
         (pin_two_source_select == 5'h02 || pin_two_source_select == 5'h03)) |=> stat_r[3];
    endproperty
    a_conflict_flag: assert property (p_conflict_flag) else $error("clash not flagged"); // [R4]

    property p_div_readback;
        @(posedge clk) disable iff (!arst_n)
        wr_div ##1 (reg_rd && reg_addr == 9'h161 && !wr_div) |=>
        reg_rdata == {3'h0, $past(reg_wdata[4:0], 2)};
    endproperty
    a_div_readback: assert property (p_div_readback) else $error("divider readback wrong"); // [R6]

    property p_follow_write;
        @(posedge clk) disable iff (!arst_n)
        (wr_cfg && reg_wdata == 8'h0B) ##1 !wr_cfg |=> pin_oe_r && pin_out_r == $past(loop_one_locked);
    endproperty
    a_follow_write: assert property (p_follow_write) else $error("pin did not follow write"); // [R8]

    property p_irq_level;
        @(posedge clk) disable iff (!arst_n)
        ((stat_r & mask_r) != '0) |=> irq_r;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

endmodule

// ===== testbench/lps_pin_mon.sv
module lps_pin_mon (
    // Pin drive from the block
    input wire logic pin_out,
    input wire logic pin_oe,
    // Level seen on the board wire
    output logic pin_level
);
    timeunit 1ns;
    timeprecision 100ps;

    // Released wire floats up through the board pull-up
    assign pin_level = pin_oe ? pin_out : 1'h1;
endmodule

// ===== testbench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import lps_pkg::*;

    logic clk = 1'h0;
    logic arst_n = 1'h0;
    lps_addr_t reg_addr = 9'h000;
    lps_data_t reg_wdata = 8'h00;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [DATA_W-1:0] reg_rdata;
    logic [15:0] src = 16'h0000;
    logic tick = 1'h0;
    logic [SEL_W-1:0] pin_two_sel = 5'h00;
    logic pin_out, pin_oe, div_pulse, irq, pin_level;
    int fails = 0;
    int cmp_count = 0;
    int pulses = 0;
    int pin_hi = 0;
    int pin_tog = 0;
    logic pin_q = 1'h0;
    logic [2:0] half_m = 3'h0;
    logic [2:0] src_q = 3'h0;

    // Clock and divider pulse counting
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (div_pulse === 1'h1) pulses++;
        if (pin_level === 1'h1) pin_hi++;
        if (pin_level !== pin_q) pin_tog++;
        pin_q = pin_level;
    end

    // Reference copy of the halved divider sources: toggle on each rise
    always @(posedge clk) begin
        half_m <= half_m ^ ({src[15], src[13], src[11]} & ~src_q);
        src_q <= {src[15], src[13], src[11]};
    end

    lps_lock_pin uut (
        .clk(clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .loop_one_locked(src[1]), .loop_two_locked(src[2]), .holdover_active(src[4]),
        .dac_locked(src[5]), .readback_bit(src[7]), .dac_rail(src[8]), .dac_low(src[9]),
        .dac_high(src[10]), .loop_one_fb_div(src[11]), .loop_two_fb_div(src[13]),
        .loop_one_ref_div(src[15]), .loop_two_ref_tick(tick),
        .pin_two_source_select(pin_two_sel),
        .status_pin_one_out(pin_out), .status_pin_one_oe(pin_oe),
        .ref_div_two_pulse(div_pulse), .irq(irq)
    );

    lps_pin_mon mon (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level));

    // Comparison and bus helpers
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(lps_addr_t a, lps_data_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask

    task automatic rd_chk(string what, lps_addr_t a, lps_data_t exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1;
        chk(what, exp, reg_rdata);
    endtask

    // Write then read back on the very next cycle
    task automatic wr_rd_chk(string what, lps_addr_t a, lps_data_t d, lps_data_t exp);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1;
        chk(what, exp, reg_rdata);
    endtask

    task automatic wait_cyc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Reset values and an unmapped read
    task automatic test_reset;
        wait_cyc(2);
        chk("reset_pin", 8'h01, {6'h00, pin_out, pin_oe});
        rd_chk("pin_cfg", OFF_PIN_CFG, 8'h0E);
        rd_chk("ref_div", OFF_REF_DIV, 8'h02);
        rd_chk("unmapped", 9'h100, 8'h00);
        $display("test reset done");
    endtask

    // Each level source alone high, then alone low, pin two kept clear
    task automatic test_mux;
        logic [15:0] one;
        logic lvl;
        for (int c = 0; c < 16; c++) begin
            if (c == 12 || c == 14) begin
                continue;
            end
            one = (c == 3) ? 16'h0006 : 16'h0001 << c;
            lvl = !(c == 0 || c == 6);
            wr(OFF_PIN_CFG, {c[4:0], TYPE_PP});
            src <= one;
            wait_cyc(3);
            chk("mux_level", {7'h00, lvl}, {7'h00, pin_level});
            @(posedge clk);
            src <= ~one;
            wait_cyc(3);
            chk("mux_inverse", 8'h00, {7'h00, pin_level});
        end
        $display("test mux done");
    endtask

    // Halved divider sources follow the reference copy
    task automatic test_half;
        logic [4:0] code;
        for (int h = 0; h < 3; h++) begin
            code = 5'(12 + 2 * h);
            wr(OFF_PIN_CFG, {code, TYPE_PP});
            for (int p = 0; p < 4; p++) begin
                @(posedge clk);
                src <= p[0] ? 16'h0000 : 16'hA800;
                wait_cyc(3);
                chk("half_level", {7'h00, half_m[h]}, {7'h00, pin_level});
            end
        end
        $display("test half done");
    endtask

    // Every drive type code against both levels
    task automatic test_types;
        logic [1:0] exp;
        for (int i = 0; i < 8; i++) begin
            wr(OFF_PIN_CFG, {SRC_LOCK_ONE, i[2:0]});
            for (int l = 0; l < 2; l++) begin
                @(posedge clk);
                src <= {14'h0000, l[0], 1'h0};
                wait_cyc(3);
                case (i)
                    3: exp = {l[0], 1'h1};
                    4: exp = {!l[0], 1'h1};
                    6: exp = {1'h0, !l[0]};
                    default: exp = 2'h0;
                endcase
                chk("pin_out_oe", {6'h00, exp}, {6'h00, pin_out, pin_oe});
            end
        end
        $display("test types done");
    endtask

    // Divide values at both ends of the range and the silent zero, also on the pin
    task automatic test_div;
        int n[4] = '{1, 3, 0, 30};
        int t[4] = '{5, 7, 4, 60};
        int e[4] = '{5, 2, 0, 2};
        for (int k = 0; k < 4; k++) begin
            wr(OFF_PIN_CFG, {(k == 1) ? SRC_REF_TWO_HALF : SRC_REF_TWO, TYPE_PP});
            wr_rd_chk("div_readback", OFF_REF_DIV, {3'h7, n[k][4:0]}, {3'h0, n[k][4:0]});
            pulses = 0;
            pin_hi = 0;
            pin_tog = 0;
            repeat (t[k]) begin
                @(posedge clk);
                tick <= 1'h1;
            end
            @(posedge clk);
            tick <= 1'h0;
            wait_cyc(3);
            chk("div_pulses", 8'(e[k]), 8'(pulses));
            chk("div_on_pin", 8'(e[k]), 8'((k == 1) ? pin_tog : pin_hi));
        end
        rd_chk("pin_state", OFF_PIN_STATE, 8'h0C);
        $display("test divider done");
    endtask

    // Level change raises, clears and is masked
    task automatic test_irq;
        @(posedge clk);
        src <= 16'h0000;
        wr(OFF_PIN_CFG, {SRC_LOCK_ONE, TYPE_PP});
        wr(OFF_IRQ_STAT, 8'h1F);
        wr(OFF_IRQ_MASK, 8'h01);
        wait_cyc(2);
        chk("irq_idle", 8'h00, {7'h00, irq});
        @(posedge clk);
        src <= 16'h0002;
        wait_cyc(3);
        chk("irq_raised", 8'h01, {7'h00, irq});
        rd_chk("irq_status", OFF_IRQ_STAT, 8'h01);
        wr(OFF_IRQ_STAT, 8'h01);
        wait_cyc(2);
        chk("irq_cleared", 8'h00, {7'h00, irq});
        wr(OFF_IRQ_MASK, 8'h00);
        src <= 16'h0000;
        wait_cyc(3);
        chk("irq_masked", 8'h00, {7'h00, irq});
        rd_chk("irq_fall", OFF_IRQ_STAT, 8'h02);
        wr(OFF_IRQ_STAT, 8'h1F);
        pin_two_sel <= PIN2_LOCK_TWO;
        wr(OFF_PIN_CFG, {SRC_REF_TWO, TYPE_PP});
        wait_cyc(2);
        rd_chk("irq_clash", OFF_IRQ_STAT, 8'h08);
        @(posedge clk);
        pin_two_sel <= 5'h00;
        wr(OFF_IRQ_STAT, 8'h1F);
        rd_chk("irq_no_clash", OFF_IRQ_STAT, 8'h00);
        $display("test interrupt done");
    endtask

    // Verdict and end of run
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'h1;
        test_reset;
        test_mux;
        test_half;
        test_types;
        test_div;
        test_irq;
        tally_and_finish;
    end

    // Watchdog, several times the expected run length
    initial begin
        #20000;
        fails++;
        tally_and_finish;
    end
endmodule
